/* File: rtl/sksub_cfg.svh */
// Purpose: Constants for the skip and subtract execution block.
// Assumes: 8-bit data path.
// Notes: Definitions only.
`ifndef SKSUB_CFG_SVH
`define SKSUB_CFG_SVH

`define SKSUB_DATA_W 8
`define SKSUB_BIT_SEL_W 3
`define SKSUB_MSB 7
`define SKSUB_NIBBLE_MSB 3
`define SKSUB_BYTE_ZERO 8'h00
`define SKSUB_WREG_RESET 8'h00

`endif

/* File: rtl/sksub_pkg.sv */
// Purpose: Types shared by the skip and subtract execution block.
// Assumes: sksub_cfg.svh is on the include path.
// Notes: Holds types only.
`include "sksub_cfg.svh"

package sksub_pkg;

  typedef enum logic [2:0] {
    SKSUB_OP_NONE,
    SKSUB_OP_SKIP_BIT_NONZERO,
    SKSUB_OP_SKIP_IF_NONZERO,
    SKSUB_OP_SUB_TO_WREG,
    SKSUB_OP_SUBTRACT_TO_MEMORY,
    SKSUB_OP_SUB_IMMEDIATE
  } sksub_op_type;

  typedef struct packed {
    sksub_op_type op;
    logic [`SKSUB_BIT_SEL_W-1:0] bit_sel;
    logic [`SKSUB_DATA_W-1:0] mem_data;
    logic [`SKSUB_DATA_W-1:0] imm_data;
  } sksub_req_type;

  typedef struct packed {
    logic overflow_flag;
    logic zero_flag;
    logic half_borrow_flag;
    logic carry_flag;
    logic signed_borrow_flag;
    logic chained_null_flag;
  } sksub_flags_type;

endpackage

/* File: rtl/sksub_subtractor.sv */
// Purpose: 8-bit subtractor producing a difference and the six arithmetic flags.
// Assumes: Two's-complement operands.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "sksub_cfg.svh"

module sksub_subtractor (
  input wire logic [`SKSUB_DATA_W-1:0] minuend,
  input wire logic [`SKSUB_DATA_W-1:0] subtrahend,
  output logic [`SKSUB_DATA_W-1:0] difference,
  output sksub_pkg::sksub_flags_type flags
);

  logic [`SKSUB_DATA_W:0] wide_diff;
  logic [`SKSUB_NIBBLE_MSB+1:0] low_diff;

  // (RULE9) Two's-complement difference.
  assign wide_diff = {1'b0, minuend} - {1'b0, subtrahend};
  assign low_diff = {1'b0, minuend[`SKSUB_NIBBLE_MSB:0]}
                  - {1'b0, subtrahend[`SKSUB_NIBBLE_MSB:0]};
  assign difference = wide_diff[`SKSUB_DATA_W-1:0];

  always_comb begin
    // (RULE5) Carry means no borrow.
    flags.carry_flag = ~wide_diff[`SKSUB_DATA_W];
    // (RULE9) Overflow, zero, half borrow.
    flags.overflow_flag = (minuend[`SKSUB_MSB] ^ subtrahend[`SKSUB_MSB])
                        & (minuend[`SKSUB_MSB] ^ difference[`SKSUB_MSB]);
    flags.zero_flag = (difference == `SKSUB_BYTE_ZERO);
    flags.half_borrow_flag = ~low_diff[`SKSUB_NIBBLE_MSB+1];
    // The signed result is below zero when sign and overflow disagree.
    flags.signed_borrow_flag = flags.overflow_flag ^ difference[`SKSUB_MSB];
    // A single-byte subtract has no earlier byte, so the chain is the plain zero.
    flags.chained_null_flag = flags.zero_flag;
  end

endmodule
`default_nettype wire

/* File: rtl/sksub_exec.sv */
// Purpose: Execution of bit and byte skip tests and three subtract forms.
// Assumes: The pipeline presents one operation per req_valid pulse with the memory byte read.
// Notes: Results appear one clock after the request.
// Notes: The block holds no instruction state; the fetch side inserts the dummy slot.
//
// What this block does
// (RULE1) Bit test: skip when selected bit set.
// (RULE2) Taken skip squashes next fetched instruction.
// (RULE3) Byte test: write back, skip if nonzero.
// (RULE4) Register minus memory into working register.
// (RULE5) Subtract carry clear on borrow only.
// (RULE6) Subtracts update flags; skips leave them.
// (RULE7) Register minus memory written to memory.
// (RULE8) Register minus immediate into working register.
// (RULE9) Eight-bit two's-complement flags derived customarily.
`timescale 1ns/1ps
`default_nettype none
`include "sksub_cfg.svh"

module sksub_exec (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire sksub_pkg::sksub_req_type req,
  output logic squash_next,
  output logic mem_wr_en,
  output logic [`SKSUB_DATA_W-1:0] mem_wr_data,
  output logic [`SKSUB_DATA_W-1:0] working_register,
  output sksub_pkg::sksub_flags_type flags
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_b_r;
  logic rst_sync_b_r;

  // The pin reset is asynchronous. Releasing it through two flops makes every
  // register of the block behind the two synchroniser flops leave reset on the same clock edge.

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b_r <= 1'b0;
      rst_sync_b_r <= 1'b0;
    end else begin
      rst_meta_b_r <= 1'b1;
      rst_sync_b_r <= rst_meta_b_r;
    end
  end

  // ----------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------
  // Each strobe is qualified by req_valid, so an idle cycle or an unknown
  // code holds the working register, the flags and mem_wr_data, and clears squash and write enable.
  logic do_skip_bit;
  logic do_skip_byte;
  logic do_sub_wreg;
  logic do_sub_mem;
  logic do_sub_imm;
  logic is_sub;

  always_comb begin
    do_skip_bit = 1'b0;
    do_skip_byte = 1'b0;
    do_sub_wreg = 1'b0;
    do_sub_mem = 1'b0;
    do_sub_imm = 1'b0;
    if (req_valid) begin
      case (req.op)
        sksub_pkg::SKSUB_OP_SKIP_BIT_NONZERO: begin
          do_skip_bit = 1'b1;
        end
        sksub_pkg::SKSUB_OP_SKIP_IF_NONZERO: begin
          do_skip_byte = 1'b1;
        end
        sksub_pkg::SKSUB_OP_SUB_TO_WREG: begin
          do_sub_wreg = 1'b1;
        end
        sksub_pkg::SKSUB_OP_SUBTRACT_TO_MEMORY: begin
          do_sub_mem = 1'b1;
        end
        sksub_pkg::SKSUB_OP_SUB_IMMEDIATE: begin
          do_sub_imm = 1'b1;
        end
        default: begin
          do_skip_bit = 1'b0;
        end
      endcase
    end
  end

  // (RULE6) Subtract class for the flags.
  assign is_sub = do_sub_wreg || do_sub_mem || do_sub_imm;

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  // The subtractor always runs; only the decode strobes decide what it updates.
  logic [`SKSUB_DATA_W-1:0] subtrahend;
  logic [`SKSUB_DATA_W-1:0] difference;
  sksub_pkg::sksub_flags_type sub_flags;

  // (RULE8) Immediate replaces the memory operand.
  assign subtrahend = (req.op == sksub_pkg::SKSUB_OP_SUB_IMMEDIATE) ? req.imm_data
                                                                     : req.mem_data;

  sksub_subtractor u_sub (
    .minuend(working_register),
    .subtrahend(subtrahend),
    .difference(difference),
    .flags(sub_flags)
  );

  // ----------------------------------------------------------------
  // Skip decision
  // ----------------------------------------------------------------
  logic skip_nxt;
  logic squash_r;
  logic [`SKSUB_DATA_W-1:0] bit_hit;
  logic bit_set;
  logic byte_set;

  // (RULE1) Per-bit select and test.
  // A decoded AND-OR keeps the selected-bit path as shallow as the byte test.
  for (genvar gi = 0; gi < `SKSUB_DATA_W; gi++) begin : g_bit_hit
    assign bit_hit[gi] = req.mem_data[gi] && (req.bit_sel == `SKSUB_BIT_SEL_W'(gi));
  end

  assign bit_set = |bit_hit;

  // (RULE3) Whole byte test.
  assign byte_set = (req.mem_data != `SKSUB_BYTE_ZERO);

  always_comb begin
    skip_nxt = 1'b0;
    if (do_skip_bit) begin
      skip_nxt = bit_set;
    end else if (do_skip_byte) begin
      skip_nxt = byte_set;
    end
  end

  // The pulse lasts one cycle; the fetch side swaps exactly that slot for a dummy.
  // (RULE2) One dummy cycle per taken skip.
  always_ff @(posedge clk_sys or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      squash_r <= 1'b0;
    end else begin
      squash_r <= skip_nxt;
    end
  end

  assign squash_next = squash_r;

  // ----------------------------------------------------------------
  // Working register
  // ----------------------------------------------------------------
  logic [`SKSUB_DATA_W-1:0] working_register_r;

  // A subtract in the very next cycle reads this register, so back-to-back
  // subtracts chain through it without any bypass path.

  always_ff @(posedge clk_sys or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      working_register_r <= `SKSUB_WREG_RESET;
    end else if (req_valid && (req.op == sksub_pkg::SKSUB_OP_SUB_TO_WREG
                            || req.op == sksub_pkg::SKSUB_OP_SUB_IMMEDIATE)) begin
      // (RULE4) Difference into working register.
      working_register_r <= difference;
    end
  end

  assign working_register = working_register_r;

  // ----------------------------------------------------------------
  // Memory write-back
  // ----------------------------------------------------------------
  logic mem_wr_en_r;
  logic [`SKSUB_DATA_W-1:0] mem_wr_data_r;

  // The write lands one cycle after the request, so the pipeline must still hold
  // the request's address then; mem_wr_data keeps its value between writes.

  always_ff @(posedge clk_sys or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      mem_wr_en_r <= 1'b0;
      mem_wr_data_r <= `SKSUB_BYTE_ZERO;
    end else begin
      mem_wr_en_r <= 1'b0;
      if (req_valid && req.op == sksub_pkg::SKSUB_OP_SUBTRACT_TO_MEMORY) begin
        // (RULE7) Difference back to memory.
        mem_wr_en_r <= 1'b1;
        mem_wr_data_r <= difference;
      end else if (req_valid && req.op == sksub_pkg::SKSUB_OP_SKIP_IF_NONZERO) begin
        // (RULE3) Same value written back.
        mem_wr_en_r <= 1'b1;
        mem_wr_data_r <= req.mem_data;
      end
    end
  end

  assign mem_wr_en = mem_wr_en_r;
  assign mem_wr_data = mem_wr_data_r;

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  sksub_pkg::sksub_flags_type flags_r;

  // Skips and idle cycles hold the flags, so a skip placed between two
  // subtracts never disturbs the carry that the second one may need.
  // (RULE6) Only subtracts touch the flags.
  always_ff @(posedge clk_sys or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      flags_r <= '0;
    end else if (is_sub) begin
      flags_r <= sub_flags;
    end
  end

  assign flags = flags_r;

endmodule
`default_nettype wire

/* File: verification/sksub_partner.sv */
// Purpose: Data memory and fetch side facing the execution block.
// Assumes: Four bytes; the bench holds the address through the answer.
// Notes: Counts the dummy slots that the fetch side inserts.
`timescale 1ns/1ps
`default_nettype none
module sksub_partner (
  input wire logic clk_sys,
  input wire logic [1:0] addr,
  input wire logic mem_wr_en,
  input wire logic [7:0] mem_wr_data,
  input wire logic squash_next,
  output logic [7:0] rd_data,
  output int dummies
);
  logic [7:0] mem [4] = '{8'h00, 8'h80, 8'h3C, 8'hFF};
  int cnt = 0;
  assign rd_data = mem[addr];
  assign dummies = cnt;
  // The write goes to the address of the request, so the bench must not move it early.
  always @(posedge clk_sys) begin
    if (mem_wr_en) begin
      mem[addr] <= mem_wr_data;
    end
  end
  always @(posedge clk_sys) begin
    if (squash_next) begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

/* File: verification/sksub_exec_assertions.sv */
// Purpose: Port checks of the skip and subtract block.
// Assumes: One clock; requests start after the reset synchroniser.
// Notes: Bound to every instance.
`timescale 1ns/1ps
`default_nettype none
module sksub_exec_assertions (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire sksub_pkg::sksub_req_type req,
  input wire logic squash_next,
  input wire logic mem_wr_en,
  input wire logic [7:0] mem_wr_data,
  input wire logic [7:0] working_register,
  input wire sksub_pkg::sksub_flags_type flags
);
  sksub_pkg::sksub_req_type q_r;
  sksub_pkg::sksub_flags_type f_r;
  logic v_r;
  logic [7:0] w_r;
  always_ff @(posedge clk_sys) begin
    v_r <= req_valid;
    q_r <= req;
    w_r <= working_register;
    f_r <= flags;
  end
  wire sb = v_r && q_r.op == sksub_pkg::SKSUB_OP_SKIP_BIT_NONZERO;
  wire sy = v_r && q_r.op == sksub_pkg::SKSUB_OP_SKIP_IF_NONZERO;
  wire sw = v_r && q_r.op == sksub_pkg::SKSUB_OP_SUB_TO_WREG;
  wire sm = v_r && q_r.op == sksub_pkg::SKSUB_OP_SUBTRACT_TO_MEMORY;
  wire si = v_r && q_r.op == sksub_pkg::SKSUB_OP_SUB_IMMEDIATE;
  wire [7:0] opd = si ? q_r.imm_data : q_r.mem_data;
  wire [7:0] dif = w_r - opd;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_sub; sw || sm || si; endsequence
  property p_bit; sb |-> squash_next == q_r.mem_data[q_r.bit_sel]; endproperty
  a_bit: assert property (p_bit) else $error("bit skip wrong");
  property p_dummy; squash_next |-> sb || sy; endproperty
  a_dummy: assert property (p_dummy) else $error("stray squash");
  property p_byte; sy |-> mem_wr_en && mem_wr_data == q_r.mem_data
    && squash_next == (q_r.mem_data != 8'h00); endproperty
  a_byte: assert property (p_byte) else $error("byte skip wrong");
  property p_wreg; sw |-> working_register == dif && !mem_wr_en; endproperty
  a_wreg: assert property (p_wreg) else $error("sub wreg wrong");
  property p_carry; s_sub |-> flags.carry_flag == (w_r >= opd); endproperty
  a_carry: assert property (p_carry) else $error("carry wrong");
  property p_hold; sb || sy |-> flags == f_r && working_register == w_r; endproperty
  a_hold: assert property (p_hold) else $error("skip changed state");
  property p_mem; sm |-> mem_wr_en && mem_wr_data == dif && working_register == w_r; endproperty
  a_mem: assert property (p_mem) else $error("sub memory wrong");
  property p_imm; si |-> working_register == dif && !mem_wr_en; endproperty
  a_imm: assert property (p_imm) else $error("sub imm wrong");
  property p_flags; s_sub |-> flags.zero_flag == (dif == 8'h00)
    && flags.overflow_flag == ((w_r[7] ^ opd[7]) & (w_r[7] ^ dif[7]))
    && flags.half_borrow_flag == (w_r[3:0] >= opd[3:0])
    && flags.signed_borrow_flag == ($signed(w_r) < $signed(opd))
    && flags.chained_null_flag == (dif == 8'h00); endproperty
  a_flags: assert property (p_flags) else $error("flags wrong");
endmodule
bind sksub_exec sksub_exec_assertions u_chk (.clk_sys, .rst_b, .req_valid, .req,
  .squash_next, .mem_wr_en, .mem_wr_data, .working_register, .flags);
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: Directed bench of the skip and subtract block.
// Assumes: Partner holds four bytes 00, 80, 3C, FF.
// Notes: Inputs change on the falling edge; at least one idle cycle between requests.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH %0t %h %h", $time, a, b); end end
module tb_top;
  logic clk_sys = 0, rst_b = 0, req_valid = 0, squash_next, mem_wr_en;
  logic [1:0] addr = 2'h0;
  logic [2:0] bs = 3'h0;
  logic [7:0] rd, mem_wr_data, working_register, w = 8'h00, imm = 8'h00, e, opd;
  int num_errors = 0, compares = 0, dummies, k = 0;
  sksub_pkg::sksub_op_type op = sksub_pkg::SKSUB_OP_NONE;
  sksub_pkg::sksub_flags_type flags, f;
  sksub_pkg::sksub_req_type req;
  assign req = '{op, bs, rd, imm};
  always #10 clk_sys = ~clk_sys;
  sksub_exec dut (.clk_sys, .rst_b, .req_valid, .req, .squash_next, .mem_wr_en,
    .mem_wr_data, .working_register, .flags);
  sksub_partner pm (.clk_sys, .addr, .mem_wr_en, .mem_wr_data, .squash_next,
    .rd_data(rd), .dummies);
  task automatic run(sksub_pkg::sksub_op_type o, logic [1:0] a, logic [7:0] x, logic [2:0] b);
    @(negedge clk_sys);
    op = o;
    addr = a;
    imm = x;
    bs = b;
    req_valid = 1'h1;
    #1 opd = (o == sksub_pkg::SKSUB_OP_SUB_IMMEDIATE) ? x : rd;
    @(negedge clk_sys);
    req_valid = 1'h0;
  endtask
  task automatic t_skip(sksub_pkg::sksub_op_type o, logic [1:0] a, logic [2:0] b);
    logic y;
    f = flags;
    run(o, a, 8'h00, b);
    y = (o == sksub_pkg::SKSUB_OP_SKIP_IF_NONZERO) ? (opd != 8'h00) : opd[b];
    k += y;
    `CHK(squash_next, y)
    `CHK(mem_wr_en, o == sksub_pkg::SKSUB_OP_SKIP_IF_NONZERO)
    `CHK({flags, working_register}, {f, w})
    @(negedge clk_sys);
    `CHK(squash_next, 1'h0)
    $display("skip test done");
  endtask
  task automatic t_sub(sksub_pkg::sksub_op_type o, logic [1:0] a, logic [7:0] x);
    int sd;
    run(o, a, x, 3'h0);
    e = w - opd;
    sd = $signed(w) - $signed(opd);
    `CHK(flags.carry_flag, w >= opd)
    `CHK({flags.zero_flag, flags.overflow_flag}, {e == 8'h00, sd > 127 || sd < -128})
    `CHK(flags.half_borrow_flag, w[3:0] >= opd[3:0])
    `CHK({flags.signed_borrow_flag, flags.chained_null_flag}, {sd < 0, e == 8'h00})
    if (o == sksub_pkg::SKSUB_OP_SUBTRACT_TO_MEMORY) begin
      `CHK({mem_wr_en, mem_wr_data, working_register}, {1'h1, e, w})
      @(negedge clk_sys);
      `CHK(rd, e)
    end else begin
      `CHK({mem_wr_en, working_register}, {1'h0, e})
      w = e;
    end
    $display("sub test done");
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #100000 num_errors++;
    report_and_stop;
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    rst_b = 1'h1;
    repeat (3) @(negedge clk_sys);
    for (int i = 0; i < 8; i++) t_skip(sksub_pkg::SKSUB_OP_SKIP_BIT_NONZERO, 2'h2, i[2:0]);
    t_skip(sksub_pkg::SKSUB_OP_SKIP_IF_NONZERO, 2'h0, 3'h0);
    t_skip(sksub_pkg::SKSUB_OP_SKIP_IF_NONZERO, 2'h3, 3'h0);
    // Borrow, then both overflow directions, then a zero result written to memory.
    t_sub(sksub_pkg::SKSUB_OP_SUB_IMMEDIATE, 2'h0, 8'h01);
    t_sub(sksub_pkg::SKSUB_OP_SUB_IMMEDIATE, 2'h0, 8'h7F);
    t_sub(sksub_pkg::SKSUB_OP_SUB_IMMEDIATE, 2'h0, 8'h01);
    t_sub(sksub_pkg::SKSUB_OP_SUB_TO_WREG, 2'h1, 8'h00);
    t_sub(sksub_pkg::SKSUB_OP_SUBTRACT_TO_MEMORY, 2'h3, 8'h00);
    t_skip(sksub_pkg::SKSUB_OP_SKIP_IF_NONZERO, 2'h3, 3'h0);
    `CHK(dummies, k)
    report_and_stop;
  end
endmodule
`default_nettype wire
